// ==== common/cdar_pkg.sv ====
// package: constants and types for the device address configuration register
package cdar_pkg;

    // ------------------------------------------------------------------
    // select code and register access prefix
    // ------------------------------------------------------------------
    // device type identifier: value is arbitrary, stands in for the real code
    localparam logic [3:0] CDAR_DEVICE_TYPE_ID = 4'hA;
    localparam logic [2:0] CDAR_REG_PREFIX = 3'h6;
    localparam int CDAR_PREFIX_HI = 7;
    localparam int CDAR_PREFIX_LO = 5;
    localparam int CDAR_SEL_TYPE_HI = 7;
    localparam int CDAR_SEL_TYPE_LO = 4;
    localparam int CDAR_SEL_CS_HI = 3;
    localparam int CDAR_SEL_CS_LO = 1;
    localparam int CDAR_SEL_RW = 0;

    // ------------------------------------------------------------------
    // register layout and delivered values
    // ------------------------------------------------------------------
    localparam int CDAR_CFG_HI = 3;
    localparam int CDAR_CFG_LO = 0;
    localparam logic [3:0] CDAR_RESERVED_READ = 4'h0;
    localparam logic [7:0] CDAR_DELIVERED_PACKAGED = 8'h00;
    localparam logic [7:0] CDAR_DELIVERED_WAFER = 8'h01;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CDAR_SYS_CLK_KHZ = 10000;
    localparam int CDAR_T_WRITE_US = 5000;
    localparam int CDAR_WRITE_CYCLES = CDAR_T_WRITE_US * CDAR_SYS_CLK_KHZ / 1000;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] chip_select;
        logic address_lock;
    } cdar_cfg_s;

    typedef enum logic [2:0] {
        CDAR_ST_IDLE = 3'b000,
        CDAR_ST_DEVSEL = 3'b001,
        CDAR_ST_ADDR_HI = 3'b010,
        CDAR_ST_ADDR_LO = 3'b011,
        CDAR_ST_WDATA = 3'b100,
        CDAR_ST_RDATA = 3'b101,
        CDAR_ST_ACK = 3'b110,
        CDAR_ST_MACK = 3'b111
    } cdar_state_e;

endpackage : cdar_pkg

// ==== hdl/cdar_top.sv ====
// design: serial target front end and non-volatile device address register
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - register reached by type id plus prefix 110
// - address bits below prefix are ignored
// - random read and single-byte page write sequences
// - chip select bits matched against select code
// - stored config loaded at power-up and reprogramming
// - lock set makes register read-only
// - more than one data byte aborts write
// - setting the lock holds until the next reset, which reloads the delivered value
// - inhibit or lock: no data ack, no write
// - upper four bits always read zero
// - one write updates select bits and lock
// - delivered value zero, or one for wafer
// - preprogrammed parts arrive locked, read-only
// - select and address acked while inhibited
// - write cycle starts only at stop
// - starts ignored while write cycle runs
module cdar_top
    import cdar_pkg::*;
#(
    parameter logic [7:0] DELIVERED_VALUE = CDAR_DELIVERED_PACKAGED,
    parameter int WRITE_CYCLES = CDAR_WRITE_CYCLES
) (
    // system clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // serial link, sampled on its own clock
    input wire logic link_clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    // write protection pin
    input wire logic write_inhibit_pin_i,
    // status
    output logic [7:0] device_address_config_o,
    output logic write_busy_o
);

    // ------------------------------------------------------------------
    // system domain: non-volatile cells and write cycle
    // ------------------------------------------------------------------
    cdar_cfg_s nv_q;
    cdar_cfg_s active_q;
    cdar_cfg_s wr_data_q;
    logic load_q;
    logic busy_q;
    logic done_q;
    logic [31:0] timer_q;
    logic req_tgl_s1_q, req_tgl_s2_q, req_tgl_p_q;
    logic ack_tgl_q;
    logic req_seen;

    // link side signals read by the system side
    logic req_tgl_q;
    cdar_cfg_s req_data_q;

    assign req_seen = req_tgl_s2_q ^ req_tgl_p_q;

    always_ff @(posedge sys_clk_i) begin
        req_tgl_s1_q <= req_tgl_q;
        req_tgl_s2_q <= req_tgl_s1_q;
        if (rst_i) begin
            req_tgl_p_q <= 1'b0;
        end else begin
            req_tgl_p_q <= req_tgl_s2_q;
        end
    end

    // cells reload the delivered value at every reset; a locked delivery can never change
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            nv_q <= cdar_cfg_s'(DELIVERED_VALUE[CDAR_CFG_HI:CDAR_CFG_LO]);
            busy_q <= 1'b0;
            done_q <= 1'b0;
            timer_q <= '0;
            wr_data_q <= '0;
            ack_tgl_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (req_seen) begin
                ack_tgl_q <= ~ack_tgl_q;
                if (!nv_q.address_lock) begin
                    wr_data_q <= req_data_q;
                    busy_q <= 1'b1;
                    timer_q <= 32'(WRITE_CYCLES);
                end
            end else if (busy_q && !done_q) begin
                if (timer_q <= 32'h1) begin
                    nv_q <= wr_data_q;
                    done_q <= 1'b1;
                end else begin
                    timer_q <= timer_q - 32'h1;
                end
            end else if (done_q) begin
                busy_q <= 1'b0;
            end
        end
    end

    // active config follows the cells only at power-up and after a write
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            active_q <= '0;
            load_q <= 1'b1;
        end else begin
            load_q <= 1'b0;
            if (load_q || done_q) begin
                active_q <= nv_q;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            device_address_config_o <= '0;
            write_busy_o <= 1'b0;
        end else begin
            device_address_config_o <= {CDAR_RESERVED_READ, active_q};
            write_busy_o <= busy_q;
        end
    end

    // ------------------------------------------------------------------
    // link domain: synchronisers
    // ------------------------------------------------------------------
    logic rst_l1_q, rst_l_q;
    logic scl_s1_q, scl_q, scl_p_q;
    logic sda_s1_q, sda_q, sda_p_q;
    logic inh_s1_q, inh_q;
    logic busy_s1_q, busy_l_q;
    logic ack_s1_q, ack_s2_q;
    cdar_cfg_s cfg_s1_q, cfg_l_q;

    always_ff @(posedge link_clk_i) begin
        rst_l1_q <= rst_i;
        rst_l_q <= rst_l1_q;
        scl_s1_q <= scl_i;
        scl_q <= scl_s1_q;
        sda_s1_q <= sda_i;
        sda_q <= sda_s1_q;
        inh_s1_q <= write_inhibit_pin_i;
        inh_q <= inh_s1_q;
        busy_s1_q <= busy_q;
        busy_l_q <= busy_s1_q;
        ack_s1_q <= ack_tgl_q;
        ack_s2_q <= ack_s1_q;
        // config changes at the reload after reset and on the same edge busy falls; both pass two stages
        cfg_s1_q <= active_q;
        cfg_l_q <= cfg_s1_q;
    end

    always_ff @(posedge link_clk_i) begin
        if (rst_l_q) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_p_q <= scl_q;
            sda_p_q <= sda_q;
        end
    end

    // ------------------------------------------------------------------
    // link domain: bus events
    // ------------------------------------------------------------------
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic blocked;
    logic wr_pend_q;

    assign scl_rise = scl_q & ~scl_p_q;
    assign scl_fall = ~scl_q & scl_p_q;
    assign start_cond = scl_q & scl_p_q & sda_p_q & ~sda_q;
    assign stop_cond = scl_q & scl_p_q & ~sda_p_q & sda_q;
    // a request in flight counts as busy until the echo comes back
    assign blocked = wr_pend_q | busy_l_q;

    // ------------------------------------------------------------------
    // link domain: byte engine
    // ------------------------------------------------------------------
    cdar_state_e state_q, next_q;
    logic [7:0] shift_q;
    logic [2:0] bit_q;
    logic ack_en_q;
    logic ack_drive_q;
    logic reg_sel_q;
    logic data_ok_q;
    logic too_many_q;
    cdar_cfg_s wr_cfg_q;
    logic [7:0] rd_byte;
    logic [7:0] rx_byte;

    assign rd_byte = {CDAR_RESERVED_READ, cfg_l_q};
    assign rx_byte = {shift_q[6:0], sda_q};

    function automatic logic sel_match(input logic [7:0] sel, input cdar_cfg_s cfg);
        sel_match = (sel[CDAR_SEL_TYPE_HI:CDAR_SEL_TYPE_LO] == CDAR_DEVICE_TYPE_ID)
            && (sel[CDAR_SEL_CS_HI:CDAR_SEL_CS_LO] == cfg.chip_select);
    endfunction : sel_match

    always_ff @(posedge link_clk_i) begin
        if (rst_l_q) begin
            state_q <= CDAR_ST_IDLE;
            next_q <= CDAR_ST_IDLE;
            shift_q <= '0;
            bit_q <= '0;
            ack_en_q <= 1'b0;
            ack_drive_q <= 1'b0;
            reg_sel_q <= 1'b0;
            data_ok_q <= 1'b0;
            too_many_q <= 1'b0;
            wr_cfg_q <= '0;
            sda_oe_o <= 1'b0;
        end else if (start_cond && !blocked) begin
            state_q <= CDAR_ST_DEVSEL;
            bit_q <= '0;
            sda_oe_o <= 1'b0;
            ack_drive_q <= 1'b0;
            data_ok_q <= 1'b0;
            too_many_q <= 1'b0;
        end else if (stop_cond) begin
            state_q <= CDAR_ST_IDLE;
            sda_oe_o <= 1'b0;
            ack_drive_q <= 1'b0;
        end else begin
            case (state_q)
                CDAR_ST_IDLE: begin
                    sda_oe_o <= 1'b0;
                end
                CDAR_ST_DEVSEL, CDAR_ST_ADDR_HI, CDAR_ST_ADDR_LO, CDAR_ST_WDATA: begin
                    if (scl_rise) begin
                        shift_q <= rx_byte;
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            state_q <= CDAR_ST_ACK;
                            ack_en_q <= 1'b1;
                            case (state_q)
                                CDAR_ST_DEVSEL: begin
                                    if (!sel_match(rx_byte, cfg_l_q)) begin
                                        ack_en_q <= 1'b0;
                                        next_q <= CDAR_ST_IDLE;
                                    end else if (rx_byte[CDAR_SEL_RW]) begin
                                        // only the register is mapped here
                                        ack_en_q <= reg_sel_q;
                                        next_q <= reg_sel_q ? CDAR_ST_RDATA : CDAR_ST_IDLE;
                                    end else begin
                                        next_q <= CDAR_ST_ADDR_HI;
                                    end
                                end
                                CDAR_ST_ADDR_HI: begin
                                    reg_sel_q <= (rx_byte[CDAR_PREFIX_HI:CDAR_PREFIX_LO]
                                        == CDAR_REG_PREFIX);
                                    next_q <= CDAR_ST_ADDR_LO;
                                end
                                CDAR_ST_ADDR_LO: begin
                                    next_q <= CDAR_ST_WDATA;
                                end
                                CDAR_ST_WDATA: begin
                                    if (inh_q || cfg_l_q.address_lock || !reg_sel_q) begin
                                        ack_en_q <= 1'b0;
                                        next_q <= CDAR_ST_IDLE;
                                    end else if (data_ok_q) begin
                                        too_many_q <= 1'b1;
                                        next_q <= CDAR_ST_WDATA;
                                    end else begin
                                        data_ok_q <= 1'b1;
                                        // the stop's own clock rise shifts shift_q again
                                        wr_cfg_q <= rx_byte[CDAR_CFG_HI:CDAR_CFG_LO];
                                        next_q <= CDAR_ST_WDATA;
                                    end
                                end
                                default: begin
                                    next_q <= CDAR_ST_IDLE;
                                end
                            endcase
                        end
                    end
                end
                CDAR_ST_ACK: begin
                    if (scl_fall) begin
                        if (!ack_drive_q) begin
                            ack_drive_q <= 1'b1;
                            sda_oe_o <= ack_en_q;
                        end else begin
                            ack_drive_q <= 1'b0;
                            state_q <= next_q;
                            bit_q <= '0;
                            if (next_q == CDAR_ST_RDATA) begin
                                shift_q <= rd_byte;
                                sda_oe_o <= ~rd_byte[7];
                            end else begin
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                end
                CDAR_ST_RDATA: begin
                    if (scl_rise) begin
                        bit_q <= bit_q + 3'h1;
                        if (bit_q == 3'h7) begin
                            state_q <= CDAR_ST_MACK;
                        end
                    end else if (scl_fall) begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_o <= ~shift_q[6];
                    end
                end
                CDAR_ST_MACK: begin
                    if (scl_fall && !ack_drive_q) begin
                        sda_oe_o <= 1'b0;
                        ack_drive_q <= 1'b1;
                    end else if (scl_rise) begin
                        // on an ack the very next fall must already load the byte
                        ack_drive_q <= ~sda_q;
                        // controller ack asks for the same register again
                        state_q <= sda_q ? CDAR_ST_IDLE : CDAR_ST_ACK;
                        next_q <= CDAR_ST_RDATA;
                        ack_en_q <= 1'b0;
                    end else if (scl_fall) begin
                        state_q <= CDAR_ST_RDATA;
                    end
                end
                default: begin
                    state_q <= CDAR_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // link domain: write request at stop, handed across by toggle
    // ------------------------------------------------------------------
    logic ack_p_q;

    always_ff @(posedge link_clk_i) begin
        if (rst_l_q) begin
            req_tgl_q <= 1'b0;
            req_data_q <= '0;
            wr_pend_q <= 1'b0;
            ack_p_q <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            ack_p_q <= ack_s2_q;
            if (ack_s2_q ^ ack_p_q) begin
                wr_pend_q <= 1'b0;
            end
            if (stop_cond && data_ok_q && !too_many_q && !blocked
                    && (state_q == CDAR_ST_WDATA)) begin
                req_tgl_q <= ~req_tgl_q;
                req_data_q <= wr_cfg_q;
                wr_pend_q <= 1'b1;
            end
        end
    end

endmodule : cdar_top

`default_nettype wire

// ==== sim/cdar_top_assertions.sv ====
// checker: port assertions for the device address register block
`timescale 1ns/1ps
`default_nettype none
module cdar_top_assertions
    import cdar_pkg::*;
#(
    parameter logic [7:0] DELIVERED_VALUE = CDAR_DELIVERED_PACKAGED,
    parameter int WRITE_CYCLES = CDAR_WRITE_CYCLES
) (
    // clocks and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic link_clk_i,
    // serial link
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic write_inhibit_pin_i,
    // status
    input wire logic [7:0] device_address_config_o,
    input wire logic write_busy_o
);
    // ----
    // helpers
    // ----
    logic [15:0] busy_len_q;
    logic [2:0] since_rst_q;
    always_ff @(posedge sys_clk_i) begin
        if (rst_i || !write_busy_o) begin
            busy_len_q <= 16'h0000;
        end else begin
            busy_len_q <= busy_len_q + 16'h0001;
        end
    end
    // the reload right after reset moves the config without a write cycle
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            since_rst_q <= 3'h0;
        end else if (since_rst_q != 3'h7) begin
            since_rst_q <= since_rst_q + 3'h1;
        end
    end
    // ----
    // assertions
    // ----
    chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        device_address_config_o[7:4] == CDAR_RESERVED_READ)
        else $error("reserved config bits not zero");
    chk_delivered_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(rst_i) |-> ##[1:4] device_address_config_o == {4'h0, DELIVERED_VALUE[3:0]})
        else $error("config not loaded with delivered value");
    chk_locked_frozen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        since_rst_q == 3'h7 && $past(device_address_config_o[0])
        |-> $stable(device_address_config_o))
        else $error("locked config changed");
    chk_change_after_cycle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        since_rst_q == 3'h7 && !$stable(device_address_config_o) |-> $past(write_busy_o))
        else $error("config changed outside a write cycle");
    chk_cycle_length: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $fell(write_busy_o) |-> busy_len_q >= WRITE_CYCLES && busy_len_q <= WRITE_CYCLES + 4)
        else $error("write cycle length wrong");
    chk_barred_no_cycle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(write_busy_o) |-> !write_inhibit_pin_i && !$past(device_address_config_o[0]))
        else $error("write cycle started while barred");
    chk_busy_no_ack: assert property (@(posedge link_clk_i) disable iff (rst_i)
        write_busy_o |-> !$rose(sda_oe_o))
        else $error("link answered during write cycle");
    chk_edge_scl_low: assert property (@(posedge link_clk_i) disable iff (rst_i)
        !$stable(sda_oe_o) |-> !scl_i && sda_o == 1'b0)
        else $error("data line moved while clock high");
    chk_holds_high: assert property (@(posedge link_clk_i) disable iff (rst_i)
        sda_oe_o && $rose(scl_i) |-> sda_oe_o [*4])
        else $error("data line released during clock high");
endmodule : cdar_top_assertions

bind cdar_top cdar_top_assertions #(
    .DELIVERED_VALUE(DELIVERED_VALUE),
    .WRITE_CYCLES(WRITE_CYCLES)
) chk_u (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .link_clk_i(link_clk_i),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .write_inhibit_pin_i(write_inhibit_pin_i),
    .device_address_config_o(device_address_config_o), .write_busy_o(write_busy_o)
);
`default_nettype wire

// ==== sim/cdar_i2c_ctl.sv ====
// partner: behavioural bus controller driving clock and open-drain data
`timescale 1ns/1ps
`default_nettype none
module cdar_i2c_ctl (
    // resolved data line
    input wire logic sda_i,
    // driven pins, clock idles high between frames
    output var logic scl_o,
    output var logic sda_low_o
);
    localparam int QTR = 60;
    initial begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end
    // data falls with clock high; serves as repeated start too
    task automatic start_cond();
        sda_low_o = 1'b0;
        #QTR scl_o = 1'b1;
        #QTR sda_low_o = 1'b1;
        #QTR scl_o = 1'b0;
        #QTR;
    endtask : start_cond
    // a stop closes every write frame; it arms the write cycle only after exactly one accepted data byte
    task automatic stop_cond();
        sda_low_o = 1'b1;
        #QTR scl_o = 1'b1;
        #QTR sda_low_o = 1'b0;
        #QTR;
    endtask : stop_cond
    task automatic put_bit(input logic b, output logic seen);
        sda_low_o = !b;
        #QTR scl_o = 1'b1;
        #QTR seen = sda_i;
        scl_o = 1'b0;
        #QTR;
    endtask : put_bit
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(b[i], s);
        end
        put_bit(1'b1, s);
        ack = !s;
    endtask : send_byte
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, s);
            b[i] = s;
        end
        put_bit(last, s);
    endtask : get_byte
endmodule : cdar_i2c_ctl
`default_nettype wire

// ==== sim/cdar_top_tb.sv ====
// testbench: register writes and reads over the serial link
`timescale 1ns/1ps
`default_nettype none
module cdar_top_tb
    import cdar_pkg::*;
;
    typedef struct packed {
        logic wip;
        logic [7:0] ahi;
        logic [7:0] data;
        logic dack;
        logic [7:0] cfg;
    } cdar_row_s;
    logic sys_clk, rst, link_clk, wip, busy, sda_o, sda_oe, scl, sda_low, a;
    logic [7:0] cfg, cur, rd;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    wire logic sda_line = !(sda_low || sda_oe);
    cdar_row_s rows [3] = '{
        '{1'b0, 8'hC0, 8'hF6, 1'b1, 8'h06},
        '{1'b1, 8'hC0, 8'h08, 1'b0, 8'h06},
        '{1'b0, 8'hDF, 8'h0A, 1'b1, 8'h0A}};
    cdar_top #(.DELIVERED_VALUE(CDAR_DELIVERED_PACKAGED), .WRITE_CYCLES(20)) dut_u (
        .sys_clk_i(sys_clk), .rst_i(rst), .link_clk_i(link_clk), .scl_i(scl),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe), .write_inhibit_pin_i(wip),
        .device_address_config_o(cfg), .write_busy_o(busy));
    cdar_i2c_ctl ctl_u (.sda_i(sda_line), .scl_o(scl), .sda_low_o(sda_low));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = !sys_clk;
    end
    initial begin
        link_clk = 1'b0;
        #1.7;
        forever #3 link_clk = !link_clk;
    end
    // ----
    // checking and closing
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            results();
        end
    end
    // ----
    // frame tasks
    // ----
    task automatic sel(input logic rd_n, input logic [2:0] cs, input logic exp);
        ctl_u.send_byte({CDAR_DEVICE_TYPE_ID, cs, rd_n}, a);
        check({7'h00, a}, {7'h00, exp});
    endtask : sel
    task automatic head(input logic [7:0] ahi);
        ctl_u.start_cond();
        sel(1'b0, cur[3:1], 1'b1);
        ctl_u.send_byte(ahi, a);
        check({7'h00, a}, 8'h01);
        ctl_u.send_byte(8'h5A, a);
        check({7'h00, a}, 8'h01);
    endtask : head
    // busy shows a few cycles after the stop, so give it time to rise first
    task automatic settle();
        repeat (10) @(posedge sys_clk);
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
        repeat (3) @(posedge sys_clk);
        check({7'h00, busy}, 8'h00);
    endtask : settle
    task automatic do_write(input logic [7:0] ahi, input logic [7:0] d, input int n,
                            output logic da);
        head(ahi);
        ctl_u.send_byte(d, da);
        repeat (n - 1) ctl_u.send_byte(d, a);
        ctl_u.stop_cond();
        settle();
    endtask : do_write
    task automatic do_read(output logic [7:0] v);
        head(8'hC0);
        ctl_u.start_cond();
        sel(1'b1, cur[3:1], 1'b1);
        ctl_u.get_byte(1'b0, v);
        check(v, cur);
        ctl_u.get_byte(1'b1, v);
        ctl_u.stop_cond();
    endtask : do_read
    // ----
    // main sequence
    // ----
    initial begin
        rst = 1'b1;
        wip = 1'b0;
        cur = CDAR_DELIVERED_PACKAGED;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check(cfg, cur);
        check({7'h00, sda_o}, 8'h00);
        foreach (rows[i]) begin
            @(posedge sys_clk);
            wip <= rows[i].wip;
            do_write(rows[i].ahi, rows[i].data, 1, a);
            check({7'h00, a}, {7'h00, rows[i].dack});
            cur = rows[i].cfg;
            check(cfg, cur);
            do_read(rd);
            check(rd, cur);
        end
        for (int c = 0; c < 8; c++) begin
            ctl_u.start_cond();
            sel(1'b0, 3'(c), 3'(c) == cur[3:1]);
            ctl_u.stop_cond();
        end
        for (int p = 0; p < 8; p++) begin
            if (p != 6) begin
                do_write({3'(p), 5'h00}, 8'h02, 1, a);
                check({7'h00, a}, 8'h00);
            end
        end
        do_write(8'hC0, 8'h04, 2, a);
        check(cfg, cur);
        // a start while the cycle runs must go unanswered
        head(8'hC0);
        ctl_u.send_byte(8'h0C, a);
        ctl_u.stop_cond();
        for (int i = 0; i < 50 && busy !== 1'b1; i++) @(posedge sys_clk);
        // the cycle ends before this frame does, so look at the config now
        check({7'h00, busy}, 8'h01);
        check(cfg, cur);
        ctl_u.start_cond();
        sel(1'b0, cur[3:1], 1'b0);
        ctl_u.stop_cond();
        settle();
        cur = 8'h0C;
        check(cfg, cur);
        do_write(8'hCF, 8'h0D, 1, a);
        cur = 8'h0D;
        check(cfg, cur);
        do_write(8'hC0, 8'h02, 1, a);
        check({7'h00, a}, 8'h00);
        do_read(rd);
        check(rd, cur);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        cur = CDAR_DELIVERED_PACKAGED;
        check(cfg, cur);
        do_read(rd);
        check(rd, cur);
        results();
    end
endmodule : cdar_top_tb
`default_nettype wire
